// *** core/sys_misc_consts.vh ***
// Notes on behaviour
// RULE1 - Period zero: no automatic measurements
// RULE2 - Period 1-6 gives 2^(3+n) s; 7 continuous
// RULE3 - Periodic measurement runs awake and asleep
// RULE4 - Supply select: 1 main, 0 battery
// RULE5 - Sleep forces battery supply for sensor
// RULE6 - One-shot start launches measurement when period zero
// RULE7 - One-shot start ignored during sleep
// RULE8 - Hardware clears one-shot bit when done
// RULE9 - Select a picks test output a
// RULE10 - Five-bit select b picks test output b
// RULE11 - Remote selects reset and wake to zero
// RULE12 - Read-only revision word, writes ignored
// RULE13 - Reference to pin unless reference disabled
// RULE14 - Reference disable resets 0, wakes 1
// RULE15 - Supply status encodes supply conditions
// RULE16 - Status 011 blocks flash, may clear fast clock
// RULE17 - Wake timer runs programmed value plus one seconds
// RULE18 - Writing one kicks and restarts watchdog
// RULE19 - Writing zero to kick does nothing
`ifndef SYS_MISC_CONSTS_VH
`define SYS_MISC_CONSTS_VH

// Register offsets are word indexes; byte address = 4 x index
`define OFS_SUPPLY_STATUS   16'h00f9
`define OFS_PROBE_A         16'h2502
`define OFS_PROBE_B         16'h2503
`define OFS_REFERENCE       16'h2704
`define OFS_REVISION        16'h2706
`define OFS_REMOTE_C        16'h2709
`define OFS_REMOTE_AB       16'h270a
`define OFS_WAKEUP_TIMER_LENGTH        16'h2880
`define OFS_TEMP_CFG        16'h28a0
`define OFS_TEMP_CTRL       16'h28b4
`define OFS_STATUS_OUT      16'h2f00

// Field positions
`define BIT_TEMP_SUPPLY     6
`define BIT_ONESHOT         6
`define BIT_KICK            7
`define BIT_REF_PIN         7
`define BIT_REF_DIS         6

// Reset and wake values
`define RST_REF_DIS         1'b0
`define WAKE_REF_DIS        1'b1
`define RST_REMOTE          3'h0

// Supply codes
`define SUPPLY_FLASH_BLOCK  3'h3

// Timing: one second at 25 MHz
`define CLK_HZ              25000000
`define SECOND_CYCLES       (`CLK_HZ)
`define PERIOD_SHIFT_BASE   3

// Arbitrary neutral revision value
`define REVISION_CODE       8'h5a

`endif

// *** core/sys_misc_control_regs.v ***
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "sys_misc_consts.vh"

module sys_misc_control_regs #(
    parameter SECOND_CYCLES = `SECOND_CYCLES
) (
    input  wire        i_core_clk,
    input  wire        i_reset,
    input  wire [15:0] i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    input  wire        i_sleep_mode,
    input  wire        i_wake_event,
    input  wire [2:0]  i_supply_status,
    input  wire        i_supply_trim_fuse,
    input  wire        i_temp_meas_done,
    input  wire [31:0] i_test_signals_a,
    input  wire [31:0] i_test_signals_b,
    output reg  [31:0] o_avs_readdata,
    output reg         o_avs_waitrequest,
    output reg         o_temp_meas_start,
    output reg         o_temp_sensor_supply_main,
    output reg         o_test_output_a,
    output reg         o_test_output_b,
    output reg  [2:0]  o_remote_probe_select_a,
    output reg  [2:0]  o_remote_probe_select_b,
    output reg  [2:0]  o_remote_probe_select_c,
    output reg         o_reference_pin_output,
    output reg         o_reference_disable,
    output reg         o_flash_write_block,
    output reg         o_fast_clock_clear,
    output reg         o_watchdog_restart,
    output reg  [7:0]  o_wakeup_timer_length,
    output reg  [15:0] o_wakeup_timer_cycles_hi
);

    // Synchronised pin inputs
    reg  [1:0]  sleep_sync;
    reg  [1:0]  wake_sync;
    reg  [1:0]  done_sync;
    reg  [1:0]  fuse_sync;
    reg  [2:0]  supply_meta;
    reg  [2:0]  supply_s;
    reg  [31:0] test_a_meta;
    reg  [31:0] test_a_s;
    reg  [31:0] test_b_meta;
    reg  [31:0] test_b_s;
    reg         done_prev;

    // Registers
    reg  [5:0]  test_probe_select_a;
    reg  [4:0]  test_probe_select_b;
    reg         reference_pin_output;
    reg         reference_disable;
    reg  [2:0]  remote_probe_select_a;
    reg  [2:0]  remote_probe_select_b;
    reg  [2:0]  remote_probe_select_c;
    reg  [7:0]  wakeup_timer_length;
    reg  [2:0]  temp_interval;
    reg         temp_sensor_supply_sel;
    reg         temp_oneshot_request;

    // Scheduler
    reg  [31:0] tick_count;
    reg  [9:0]  second_count;
    reg         meas_busy;
    reg         bus_done;

    wire        sleep_s  = sleep_sync[1];
    wire        wake_s   = wake_sync[1];
    wire        done_s   = done_sync[1];
    wire        done_rise = done_s & ~done_prev;
    wire        access   = (i_avs_read | i_avs_write) & ~bus_done;
    wire        wr       = i_avs_write & ~bus_done & i_avs_byteenable[0];
    wire [15:0] index    = {2'h0, i_avs_address[15:2]};
    wire [7:0]  wd       = i_avs_writedata[7:0];
    reg  [31:0] next_readdata;

    // Control-byte strobes and the one-second wrap
    wire        ctrl_wr     = wr & (index == `OFS_TEMP_CTRL);
    wire        oneshot_wr  = ctrl_wr & wd[`BIT_ONESHOT];
    wire        kick_wr     = ctrl_wr & wd[`BIT_KICK];
    wire        second_wrap = (tick_count == SECOND_CYCLES - 1);

    // Period length in seconds; zero means none, all-ones continuous
    function [9:0] period_seconds;
        input [2:0] field;
        begin
            period_seconds = 10'h001 << (`PERIOD_SHIFT_BASE + field);
        end
    endfunction

    // Supply code that blocks flash writes
    function supply_blocks_flash;
        input [2:0] code;
        begin
            supply_blocks_flash = (code == `SUPPLY_FLASH_BLOCK);
        end
    endfunction

    // Two-flop synchronisers; first stage read only by second
    always @(posedge i_core_clk) begin
        sleep_sync  <= {sleep_sync[0], i_sleep_mode};
        wake_sync   <= {wake_sync[0], i_wake_event};
        done_sync   <= {done_sync[0], i_temp_meas_done};
        fuse_sync   <= {fuse_sync[0], i_supply_trim_fuse};
    end

    // Word synchronisers; the supply code must settle slower than two cycles
    always @(posedge i_core_clk) begin
        supply_meta <= i_supply_status;
        supply_s    <= supply_meta;
        test_a_meta <= i_test_signals_a;
        test_a_s    <= test_a_meta;
        test_b_meta <= i_test_signals_b;
        test_b_s    <= test_b_meta;
    end

    // Edge detect on the synchronised done; idles low like its pin
    always @(posedge i_core_clk) begin
        done_prev <= done_s;
    end

    // Bus handshake: one wait cycle, answer on second
    // A request still held at its answer is not taken twice
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            bus_done          <= 1'b0;
            o_avs_waitrequest <= 1'b1;
        end else begin
            bus_done          <= access;
            o_avs_waitrequest <= ~access;
        end
    end

    // Read decode; unmapped reads zero
    always @* begin
        next_readdata = 32'h0;
        case (index)
            // RULE15 status readback
            `OFS_SUPPLY_STATUS: next_readdata[2:0] = supply_s;
            `OFS_PROBE_A:       next_readdata[5:0] = test_probe_select_a;
            `OFS_PROBE_B:       next_readdata[4:0] = test_probe_select_b;
            `OFS_REFERENCE:     next_readdata[7:6] = {reference_pin_output, reference_disable};
            // RULE12 fixed revision
            `OFS_REVISION:      next_readdata[7:0] = `REVISION_CODE;
            `OFS_REMOTE_C:      next_readdata[2:0] = remote_probe_select_c;
            `OFS_REMOTE_AB:     next_readdata[7:0] = {1'b0, remote_probe_select_b,
                                                      1'b0, remote_probe_select_a};
            `OFS_WAKEUP_TIMER_LENGTH:      next_readdata[7:0] = wakeup_timer_length;
            `OFS_TEMP_CFG:      next_readdata[7:0] = {1'b0, temp_sensor_supply_sel,
                                                      3'h0, temp_interval};
            // RULE19 kick bit reads zero
            `OFS_TEMP_CTRL:     next_readdata[7:0] = {1'b0, temp_oneshot_request, 6'h0};
            // Guard flags, read only
            `OFS_STATUS_OUT:    next_readdata[1:0] = {o_fast_clock_clear, o_flash_write_block};
            default:            next_readdata = 32'h0;
        endcase
    end

    // Read data held until the next access
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_avs_readdata <= 32'h0;
        end else if (access) begin
            o_avs_readdata <= next_readdata;
        end
    end

    // Register writes with wake values
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            test_probe_select_a    <= 6'h00;
            test_probe_select_b    <= 5'h00;
            reference_pin_output   <= 1'b0;
            reference_disable      <= `RST_REF_DIS;
            remote_probe_select_a  <= `RST_REMOTE;
            remote_probe_select_b  <= `RST_REMOTE;
            remote_probe_select_c  <= `RST_REMOTE;
            wakeup_timer_length    <= 8'h00;
            temp_interval          <= 3'h0;
            temp_sensor_supply_sel <= 1'b0;
        end else if (wake_s) begin
            // Wake values win over a write in the same cycle
            // RULE11 remote selects wake zero
            remote_probe_select_a <= `RST_REMOTE;
            remote_probe_select_b <= `RST_REMOTE;
            remote_probe_select_c <= `RST_REMOTE;
            reference_pin_output  <= 1'b0;
            // RULE14 disable set on wake
            reference_disable     <= `WAKE_REF_DIS;
        end else if (wr) begin
            case (index)
                `OFS_PROBE_A:   test_probe_select_a <= wd[5:0];
                `OFS_PROBE_B:   test_probe_select_b <= wd[4:0];
                `OFS_REFERENCE: begin
                    reference_pin_output <= wd[`BIT_REF_PIN];
                    reference_disable    <= wd[`BIT_REF_DIS];
                end
                `OFS_REMOTE_C:  remote_probe_select_c <= wd[2:0];
                `OFS_REMOTE_AB: begin
                    remote_probe_select_a <= wd[2:0];
                    remote_probe_select_b <= wd[6:4];
                end
                `OFS_WAKEUP_TIMER_LENGTH:  wakeup_timer_length <= wd;
                `OFS_TEMP_CFG: begin
                    temp_interval          <= wd[2:0];
                    temp_sensor_supply_sel <= wd[`BIT_TEMP_SUPPLY];
                end
                // RULE12 revision and status have no write path
                default: ;
            endcase
        end
    end

    // One-shot request: set by write, cleared by hardware when done
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            temp_oneshot_request <= 1'b0;
        end else if (oneshot_wr && temp_interval == 3'h0 && !sleep_s) begin
            // RULE6 RULE7 launch unless asleep
            temp_oneshot_request <= 1'b1;
        end else if (done_rise) begin
            // RULE8 clear on completion
            temp_oneshot_request <= 1'b0;
        end
    end

    // One-second prescaler, free running in every power mode
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            tick_count <= 32'h0;
        end else if (second_wrap) begin
            tick_count <= 32'h0;
        end else begin
            tick_count <= tick_count + 32'h1;
        end
    end

    // Measurement scheduler; counts seconds in every power mode
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            second_count      <= 10'h000;
            meas_busy         <= 1'b0;
            o_temp_meas_start <= 1'b0;
        end else begin
            o_temp_meas_start <= 1'b0;
            // A slow measurement delays the next start; the interval restarts there
            if (second_wrap) begin
                second_count <= second_count + 10'h001;
            end
            if (done_rise) begin
                meas_busy <= 1'b0;
            end
            if (!meas_busy && !o_temp_meas_start) begin
                // RULE1 RULE3 zero period runs only one-shots
                if (temp_interval == 3'h0) begin
                    // RULE7 a request never starts while asleep
                    if (temp_oneshot_request && !sleep_s) begin
                        meas_busy         <= 1'b1;
                        o_temp_meas_start <= 1'b1;
                    end
                // RULE2 continuous back to back
                end else if (temp_interval == 3'h7) begin
                    meas_busy         <= 1'b1;
                    o_temp_meas_start <= 1'b1;
                // RULE2 power-of-two interval
                end else if (second_count >= period_seconds(temp_interval)) begin
                    second_count      <= 10'h000;
                    meas_busy         <= 1'b1;
                    o_temp_meas_start <= 1'b1;
                end
            end
        end
    end

    // Sensor supply; sleep overrides the select bit
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_temp_sensor_supply_main <= 1'b0;
        end else begin
            // RULE4 RULE5 sleep forces battery
            o_temp_sensor_supply_main <= temp_sensor_supply_sel & ~sleep_s;
        end
    end

    // Probe outputs; a probe lags its pin by three cycles
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_test_output_a         <= 1'b0;
            o_test_output_b         <= 1'b0;
            o_remote_probe_select_a <= 3'h0;
            o_remote_probe_select_b <= 3'h0;
            o_remote_probe_select_c <= 3'h0;
        end else begin
            // RULE9 only 32 signals; top select bit unused
            o_test_output_a         <= test_a_s[test_probe_select_a[4:0]];
            // RULE10 select b
            o_test_output_b         <= test_b_s[test_probe_select_b];
            // RULE11 remote selects forwarded
            o_remote_probe_select_a <= remote_probe_select_a;
            o_remote_probe_select_b <= remote_probe_select_b;
            o_remote_probe_select_c <= remote_probe_select_c;
        end
    end

    // Reference routing
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_reference_pin_output <= 1'b0;
            o_reference_disable    <= 1'b0;
        end else begin
            // RULE13 disable overrides pin routing
            o_reference_pin_output <= reference_pin_output & ~reference_disable;
            o_reference_disable    <= reference_disable;
        end
    end

    // Supply guards; follow the synchronised code with no hysteresis
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_flash_write_block <= 1'b0;
            o_fast_clock_clear  <= 1'b0;
        end else begin
            // RULE16 flash block and fast clock clear
            o_flash_write_block <= supply_blocks_flash(supply_s);
            o_fast_clock_clear  <= supply_blocks_flash(supply_s) & fuse_sync[1];
        end
    end

    // Watchdog pulse and wake timer length
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_watchdog_restart       <= 1'b0;
            o_wakeup_timer_length    <= 8'h00;
            o_wakeup_timer_cycles_hi <= 16'h0000;
        end else begin
            // RULE18 RULE19 pulse only on a one
            o_watchdog_restart       <= kick_wr;
            // RULE17 duration is value plus one seconds
            o_wakeup_timer_length    <= wakeup_timer_length;
            o_wakeup_timer_cycles_hi <= {8'h00, wakeup_timer_length} + 16'h0001;
        end
    end

endmodule // sys_misc_control_regs

// *** verif/sys_misc_checks_asserts.sv ***
`timescale 1ns/100ps
// Port watcher; latencies allow for the two-flop input synchronisers
module sys_misc_checks (
    input logic        i_core_clk,
    input logic        i_reset,
    input logic [15:0] i_avs_address,
    input logic        i_avs_read,
    input logic        i_avs_write,
    input logic [31:0] i_avs_writedata,
    input logic        i_sleep_mode,
    input logic        i_wake_event,
    input logic [2:0]  i_supply_status,
    input logic [31:0] o_avs_readdata,
    input logic        o_avs_waitrequest,
    input logic        o_temp_sensor_supply_main,
    input logic [2:0]  o_remote_probe_select_a,
    input logic        o_reference_pin_output,
    input logic        o_reference_disable,
    input logic        o_flash_write_block,
    input logic        o_watchdog_restart,
    input logic [7:0]  o_wakeup_timer_length,
    input logic [15:0] o_wakeup_timer_cycles_hi
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    chk_ref_pin_gate: assert property (
        o_reference_pin_output |-> !o_reference_disable) else $error("ref pin while disabled");
    chk_flash_blocked: assert property (
        (i_supply_status == 3'h3)[*5] |-> o_flash_write_block) else $error("flash not blocked");
    chk_flash_free: assert property (
        (i_supply_status != 3'h3)[*5] |-> !o_flash_write_block) else $error("flash blocked");
    chk_sleep_battery: assert property (
        i_sleep_mode[*5] |-> !o_temp_sensor_supply_main) else $error("main supply in sleep");
    chk_kick_pulse: assert property (
        i_avs_write && !o_avs_waitrequest && i_avs_address == 16'ha2d0 && i_avs_writedata[7]
        |-> ##[0:2] o_watchdog_restart) else $error("no restart pulse");
    chk_kick_single: assert property (
        o_watchdog_restart |=> !o_watchdog_restart) else $error("restart held");
    chk_wake_length: assert property (
        $stable(o_wakeup_timer_length)[*3] |->
        o_wakeup_timer_cycles_hi == {8'h00, o_wakeup_timer_length} + 16'h0001)
        else $error("timer length mismatch");
    chk_revision_read: assert property (
        i_avs_read && !o_avs_waitrequest && i_avs_address == 16'h9c18 |->
        o_avs_readdata[7:0] == 8'h5a) else $error("bad revision");
    chk_wake_remote: assert property (
        i_wake_event[*3] |-> ##[0:3] o_remote_probe_select_a == 3'h0) else $error("remote kept");
    chk_wake_refdis: assert property (
        i_wake_event[*3] |-> ##[0:3] o_reference_disable) else $error("ref not disabled");
    cover property (o_watchdog_restart);
    cover property (o_flash_write_block);
    cover property (i_wake_event ##1 !i_wake_event);
endmodule // sys_misc_checks

bind sys_misc_control_regs sys_misc_checks sys_misc_checks_inst (.*);

// *** verif/sys_misc_control_regs_bench.sv ***
`timescale 1ns/100ps
// Bench with an int-map register model; short seconds keep periods brief
module sys_misc_control_regs_bench;
    localparam int SEC = 10;
    logic        clk = 0;
    logic        rst = 1;
    logic [15:0] addr = 0;
    logic        rd_s = 0;
    logic        wr_s = 0;
    logic [31:0] wdata = 0;
    logic        sleep_mode = 0;
    logic        wake = 0;
    logic [2:0]  sup = 0;
    logic        fuse = 0;
    logic        done = 0;
    logic [31:0] sig_a = 0;
    logic [31:0] sig_b = 0;
    logic [7:0]  q;
    wire  [31:0] rdata;
    wire         wait_r, start, sup_main, out_a, out_b, ref_pin, ref_dis, flash, fast, kick;
    wire  [15:0] wcyc;
    wire  [2:0]  rs_a, rs_b, rs_c;
    wire  [7:0]  wlen;
    int seed = 32'h9f53f7ab;
    int miscompares = 0, n_checks = 0, cyc = 0, starts = 0, last = 0, gap = 0;
    int kicks = 0, dcnt = 0, s, e, k;
    int mdl[int];
    int regs[7] = '{'h2502, 'h2503, 'h2704, 'h2709, 'h270a, 'h2880, 'h28a0};

    always #20 clk = ~clk;

    sys_misc_control_regs #(.SECOND_CYCLES(SEC)) sys_misc_control_regs_inst (
        .i_core_clk(clk), .i_reset(rst), .i_avs_address(addr), .i_avs_read(rd_s),
        .i_avs_write(wr_s), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .i_sleep_mode(sleep_mode), .i_wake_event(wake), .i_supply_status(sup),
        .i_supply_trim_fuse(fuse), .i_temp_meas_done(done), .i_test_signals_a(sig_a),
        .i_test_signals_b(sig_b), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
        .o_temp_meas_start(start), .o_temp_sensor_supply_main(sup_main),
        .o_test_output_a(out_a), .o_test_output_b(out_b), .o_remote_probe_select_a(rs_a),
        .o_remote_probe_select_b(rs_b), .o_remote_probe_select_c(rs_c),
        .o_reference_pin_output(ref_pin), .o_reference_disable(ref_dis),
        .o_flash_write_block(flash), .o_fast_clock_clear(fast), .o_watchdog_restart(kick),
        .o_wakeup_timer_length(wlen), .o_wakeup_timer_cycles_hi(wcyc));

    // Sensor stand-in: raises done 18 cycles after the edge that samples each start
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (start === 1'b1) begin
            starts <= starts + 1;
            gap <= cyc - last;
            last <= cyc;
            dcnt <= 20;
        end else if (dcnt != 0) dcnt <= dcnt - 1;
        done <= (dcnt >= 1 && dcnt <= 3);
        if (kick === 1'b1) kicks <= kicks + 1;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until waitrequest is sampled low, released after it
    task bus(input logic wr, input int idx, input logic [7:0] d);
        addr <= {idx[13:0], 2'b00};
        rd_s <= !wr;
        wr_s <= wr;
        wdata <= {24'h0, d};
        do @(posedge clk); while (wait_r !== 1'b0);
        q = rdata[7:0];
        rd_s <= 0;
        wr_s <= 0;
        @(posedge clk);
    endtask
    function int msk(input int a);
        case (a)
            'h2502: return 'h3f;
            'h2503: return 'h1f;
            'h2704: return 'hc0;
            'h2709: return 'h07;
            'h270a: return 'h77;
            'h2880: return 'hff;
            'h28a0: return 'h47;
            default: return 0;
        endcase
    endfunction
    task wr(input int a, input int d);
        bus(1, a, 8'(d));
        if (msk(a) != 0) mdl[a] = d & msk(a);
    endtask
    task rd(input int a);
        bus(0, a, 8'h00);
        check(q, a == 'h2706 ? 'h5a : (mdl.exists(a) ? mdl[a] : 0));
    endtask
    task waitc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, well beyond the few thousand cycles the tests need
    initial begin
        #2400000;
        miscompares++;
        results;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        foreach (regs[i]) if (i > 1) rd(regs[i]);
        foreach (regs[i]) wr(regs[i], $random(seed));
        wr('h2706, 'hff);
        foreach (regs[i]) rd(regs[i]);
        rd('h2706);
        rd('h1234);
        $display("test registers ended");
        for (int i = 0; i < 4; i++) begin
            s = $random(seed) & 31;
            sig_a <= $random(seed);
            sig_b <= $random(seed);
            wr('h2502, s);
            wr('h2503, 31 - s);
            waitc(5);
            check(out_a, sig_a[s]);
            check(out_b, sig_b[31 - s]);
        end
        wr('h2704, 'h80);
        waitc(3);
        check(ref_pin, 1);
        wr('h2704, 'hc0);
        waitc(3);
        check({ref_pin, ref_dis}, 1);
        wr('h28a0, 'h40);
        waitc(3);
        check(sup_main, 1);
        sleep_mode <= 1;
        waitc(6);
        check(sup_main, 0);
        k = starts;
        wr('h28b4, 'h40);
        waitc(40);
        check(starts, k);
        sleep_mode <= 0;
        waitc(6);
        wr('h28b4, 'h40);
        bus(0, 'h28b4, 8'h00);
        check(q[6], 1);
        waitc(50);
        check(starts, k + 1);
        bus(0, 'h28b4, 8'h00);
        check(q[6], 0);
        waitc(400);
        check(starts, k + 1);
        // Third pass repeats period one while asleep
        for (int p = 1; p < 4; p++) begin
            sleep_mode <= (p == 3);
            e = (p == 3) ? 1 : p;
            wr('h28a0, e);
            k = starts;
            for (int n = 0; n < 20000 && starts < k + 3; n++) @(posedge clk);
            e = (1 << (3 + e)) * SEC;
            check(gap >= e - 2 && gap <= e + 2, 1);
        end
        sleep_mode <= 0;
        wr('h28a0, 'h07);
        k = starts;
        waitc(150);
        check(starts >= k + 3, 1);
        wr('h28a0, 'h00);
        $display("test temperature ended");
        k = kicks;
        wr('h28b4, 'h80);
        waitc(4);
        check(kicks, k + 1);
        wr('h28b4, 'h00);
        waitc(4);
        bus(0, 'h28b4, 8'h00);
        check({kicks[30:0], q[7]}, (k + 1) * 2);
        s = $random(seed) & 255;
        wr('h2880, s);
        waitc(3);
        check(wcyc, s + 1);
        check(wlen, s);
        for (int c = 0; c < 8; c++) begin
            sup <= 3'(c);
            fuse <= 1'($random(seed));
            waitc(6);
            bus(0, 'hf9, 8'h00);
            check(q[2:0], c);
            check({flash, fast}, {c == 3, c == 3 && fuse});
        end
        wr('h2709, 'h05);
        wr('h270a, 'h35);
        wr('h2704, 'h80);
        waitc(2);
        check({rs_c, rs_b, rs_a}, 9'h15d);
        wake <= 1;
        waitc(3);
        wake <= 0;
        waitc(5);
        mdl['h2709] = 0;
        mdl['h270a] = 0;
        mdl['h2704] = 'h40;
        check({rs_c, rs_b, rs_a, ref_pin, ref_dis}, 1);
        rd('h2709);
        rd('h270a);
        rd('h2704);
        $display("test wake ended");
        results;
    end
endmodule // sys_misc_control_regs_bench
